/* File: verilog/adcsq_pkg.sv */
// adcsq_pkg: constants and types shared by the converter sequencer files
package adcsq_pkg;
  // converter control register fields
  localparam int CTL_ON = 0;  // converter power on
  localparam int CTL_DONE = 1;  // completion flag
  localparam int CTL_GO = 2;  // go / busy flag
  localparam int CTL_CH_LO = 3;  // channel field low bit
  localparam int CTL_CH_HI = 4;  // channel field high bit
  localparam int CTL_CS_LO = 6;  // clock select low bit
  localparam int CTL_CS_HI = 7;  // clock select high bit
  localparam logic [7:0] CTL_RESET = 8'h00;
  // interrupt control register fields
  localparam int INT_IE = 6;  // converter interrupt enable
  localparam int INT_GIE = 7;  // global interrupt enable
  localparam logic [7:0] INT_RESET = 8'h00;
  // port configuration register
  localparam int CFG_LO = 0;  // pin_cfg_field_lo position
  localparam int CFG_HI = 1;  // pin_cfg_field_hi position
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [7:0] RES_RESET = 8'h00;
  // analog pin masks per configuration code
  localparam logic [3:0] CFG_MASK_0 = 4'hF;
  localparam logic [3:0] CFG_MASK_1 = 4'h7;
  localparam logic [3:0] CFG_MASK_2 = 4'h3;
  localparam logic [3:0] CFG_MASK_3 = 4'h0;
  // clock select codes and divide ratios
  localparam logic [1:0] CS_DIV2 = 2'h0;
  localparam logic [1:0] CS_DIV8 = 2'h1;
  localparam logic [1:0] CS_DIV32 = 2'h2;
  localparam logic [1:0] CS_RC = 2'h3;
  localparam logic [4:0] DIV2_LAST = 5'h01;
  localparam logic [4:0] DIV8_LAST = 5'h07;
  localparam logic [4:0] DIV32_LAST = 5'h1F;
  // index of the first decided bit, counted down to zero (eight decisions)
  localparam logic [2:0] LAST_BIT = 3'h7;
  // sequencer states
  typedef enum logic {ADCSQ_TRACK, ADCSQ_CONV} adcsq_state_t;
endpackage

/* File: verilog/adcsq_tad_gen.sv */
// adcsq_tad_gen: conversion clock enable from core divider or rc oscillator
`timescale 1ns/1ps
module adcsq_tad_gen
  import adcsq_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // control
  input wire logic run,
  input wire logic [1:0] clk_sel,
  input wire logic rc_rise,
  // one-cycle conversion clock enable
  output logic tad_tick
);
  logic [4:0] cnt_r;  // divider count
  logic [4:0] last;  // terminal count for the selected ratio

  always_comb begin
    case (clk_sel)
      CS_DIV2: last = DIV2_LAST;
      CS_DIV8: last = DIV8_LAST;
      CS_DIV32: last = DIV32_LAST;
      default: last = DIV32_LAST;
    endcase
  end

  // tick on terminal count or rc edge
  always_comb begin
    if (!run) begin
      tad_tick = 1'b0;
    end else if (clk_sel == CS_RC) begin
      tad_tick = rc_rise;
    end else begin
      tad_tick = (cnt_r == last);
    end
  end

  // divider counter, held clear while idle so each conversion starts aligned
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_r <= 5'h00;
    end else if (!run || cnt_r == last) begin
      cnt_r <= 5'h00;
    end else begin
      cnt_r <= cnt_r + 5'h01;
    end
  end
endmodule

/* File: verilog/adcsq_top.sv */
// adcsq_top: converter sequencer, result store and shared pin configuration
`timescale 1ns/1ps
module adcsq_top
  import adcsq_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // converter control register access
  input wire logic ctrl_wr,
  input wire logic [7:0] ctrl_wdata,
  output logic [7:0] ctrl_rdata,
  // port configuration register access
  input wire logic cfg_wr,
  input wire logic [7:0] cfg_wdata,
  output logic [7:0] cfg_rdata,
  // interrupt control register access
  input wire logic intc_wr,
  input wire logic [7:0] intc_wdata,
  output logic [7:0] intc_rdata,
  // result register access
  input wire logic res_wr,
  input wire logic [7:0] res_wdata,
  output logic [7:0] res_rdata,
  // core status and requests
  input wire logic core_sleep,
  output logic irq,
  output logic wake,
  // analog front end
  input wire logic rc_osc,
  input wire logic comp_hi,
  output logic [7:0] dac_code,
  output logic [1:0] mux_chan,
  output logic hold,
  // shared analog pins
  input wire logic [3:0] shared_analog_pins_in,
  input wire logic [3:0] port_latch,
  input wire logic [3:0] port_dir_in,
  output logic [3:0] shared_analog_pins_out,
  output logic [3:0] shared_analog_pins_oe,
  output logic [3:0] port_read
);
  ////////////////////////////////////////////////////////////////////////////
  // declarations
  adcsq_state_t state_r;  // tracking or converting
  logic [7:0] ctrl_r;  // converter_control_reg
  logic [7:0] cfg_r;  // port_analog_config_reg
  logic [7:0] intc_r;  // interrupt_control_reg
  logic [7:0] res_r;  // result register
  logic [7:0] trial_r;  // successive approximation trial code
  logic [2:0] bit_r;  // bit under decision
  logic [1:0] conv_chan_r;  // channel locked for this conversion
  logic [1:0] mux_chan_r;  // channel driven to the mux
  logic hold_r;  // sampling switch open
  logic irq_r;  // interrupt request
  logic wake_r;  // wake request
  logic [3:0] pin_s1_r;  // pin synchroniser first stage
  logic [3:0] pin_s2_r;  // pin synchroniser second stage
  logic [3:0] port_read_r;  // port read value
  logic [3:0] pin_out_r;  // pin output value
  logic [3:0] pin_oe_r;  // pin output enable
  logic rc_s1_r;  // rc synchroniser first stage
  logic rc_s2_r;  // rc synchroniser second stage
  logic rc_s3_r;  // rc edge history
  logic tad_tick;  // conversion clock enable
  logic start;  // conversion begins
  logic abort;  // conversion dropped
  logic finish;  // last decision taken
  logic [7:0] decided;  // trial after this decision
  logic [7:0] onehot_next;  // next bit to try
  logic [3:0] analog_mask;  // pins configured analog

  // analog mask per configuration code
  function automatic logic [3:0] cfg_mask(input logic [1:0] code);
    case (code)
      2'h0: cfg_mask = CFG_MASK_0;
      2'h1: cfg_mask = CFG_MASK_1;
      2'h2: cfg_mask = CFG_MASK_2;
      default: cfg_mask = CFG_MASK_3;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // sequencing terms

  // go start needs power already on
  assign start = ctrl_wr && ctrl_wdata[CTL_GO] && ctrl_wdata[CTL_ON] && ctrl_r[CTL_ON]
                 && state_r == ADCSQ_TRACK;
  assign abort = state_r == ADCSQ_CONV && ctrl_wr
                 && (!ctrl_wdata[CTL_GO] || !ctrl_wdata[CTL_ON]);
  assign finish = state_r == ADCSQ_CONV && tad_tick && bit_r == 3'h0 && !abort;
  // keep the trial bit if the input is at or above the trial level
  assign decided = comp_hi ? trial_r : (trial_r & ~(8'h01 << bit_r));
  assign onehot_next = 8'h01 << (bit_r - 3'h1);
  assign analog_mask = cfg_mask(cfg_r[CFG_HI:CFG_LO]);

  // conversion clock divider
  adcsq_tad_gen adcsq_tad_gen_i (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .run(state_r == ADCSQ_CONV),
    .clk_sel(ctrl_r[CTL_CS_HI:CTL_CS_LO]),
    .rc_rise(rc_s2_r && !rc_s3_r),
    .tad_tick(tad_tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // synchronisers

  // rc oscillator pin, edge taken from the second stage onward
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rc_s1_r <= 1'b0;
      rc_s2_r <= 1'b0;
      rc_s3_r <= 1'b0;
    end else begin
      rc_s1_r <= rc_osc;
      rc_s2_r <= rc_s1_r;
      rc_s3_r <= rc_s2_r;
    end
  end

  // shared pin inputs
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      pin_s1_r <= 4'h0;
      pin_s2_r <= 4'h0;
    end else begin
      pin_s1_r <= shared_analog_pins_in;
      pin_s2_r <= pin_s1_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers written by firmware

  // control register; hardware completion wins over a same-cycle write
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_r <= CTL_RESET;
    end else begin
      if (ctrl_wr) begin
        ctrl_r <= ctrl_wdata;
        // go held only with power on
        ctrl_r[CTL_GO] <= ctrl_wdata[CTL_GO] && ctrl_wdata[CTL_ON]
                          && (ctrl_r[CTL_ON] || state_r == ADCSQ_CONV);
      end
      if (finish) begin
        ctrl_r[CTL_GO] <= 1'b0;
        ctrl_r[CTL_DONE] <= 1'b1;
      end
    end
  end

  // port configuration and interrupt control
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg_r <= CFG_RESET;
      intc_r <= INT_RESET;
    end else begin
      if (cfg_wr) begin
        cfg_r <= cfg_wdata;
      end
      if (intc_wr) begin
        intc_r <= intc_wdata;
      end
    end
  end

  // result written by hardware only at end
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      res_r <= RES_RESET;
    end else if (finish) begin
      // new value present as go clears
      res_r <= decided;
    end else if (res_wr) begin
      res_r <= res_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // conversion sequencer

  // state and successive approximation
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= ADCSQ_TRACK;
      trial_r <= 8'h00;
      bit_r <= LAST_BIT;
      conv_chan_r <= 2'h0;
    end else begin
      case (state_r)
        ADCSQ_TRACK: begin
          if (start) begin
            state_r <= ADCSQ_CONV;
            trial_r <= 8'h80;
            bit_r <= LAST_BIT;
            conv_chan_r <= ctrl_wdata[CTL_CH_HI:CTL_CH_LO];
          end
        end
        ADCSQ_CONV: begin
          if (abort || finish) begin
            state_r <= ADCSQ_TRACK;
          end else if (tad_tick) begin
            trial_r <= decided | onehot_next;
            bit_r <= bit_r - 3'h1;
          end
        end
        default: state_r <= ADCSQ_TRACK;
      endcase
    end
  end

  // mux channel and hold switch
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      mux_chan_r <= 2'h0;
      hold_r <= 1'b0;
    end else if (start) begin
      mux_chan_r <= ctrl_wdata[CTL_CH_HI:CTL_CH_LO];
      hold_r <= 1'b1;
    end else if (state_r == ADCSQ_CONV && !abort && !finish) begin
      mux_chan_r <= conv_chan_r;
      hold_r <= 1'b1;
    end else begin
      mux_chan_r <= ctrl_r[CTL_CH_HI:CTL_CH_LO];
      hold_r <= 1'b0;
    end
  end

  // interrupt and wake requests
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_r <= 1'b0;
      wake_r <= 1'b0;
    end else begin
      irq_r <= ctrl_r[CTL_DONE] && intc_r[INT_IE] && intc_r[INT_GIE];
      // completion with enable wakes sleeping core
      wake_r <= ctrl_r[CTL_DONE] && intc_r[INT_IE] && core_sleep;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // shared pins

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      port_read_r <= 4'h0;
      pin_out_r <= 4'h0;
      pin_oe_r <= 4'h0;
    end else begin
      port_read_r <= pin_s2_r & ~analog_mask;
      // driver follows direction regardless of mode
      pin_out_r <= port_latch;
      pin_oe_r <= ~port_dir_in;
    end
  end

  // outputs straight from flops
  assign ctrl_rdata = ctrl_r;
  assign cfg_rdata = cfg_r;
  assign intc_rdata = intc_r;
  assign res_rdata = res_r;
  assign irq = irq_r;
  assign wake = wake_r;
  assign dac_code = trial_r;
  assign mux_chan = mux_chan_r;
  assign hold = hold_r;
  assign shared_analog_pins_out = pin_out_r;
  assign shared_analog_pins_oe = pin_oe_r;
  assign port_read = port_read_r;

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  AST_GO_START: assert property (start |=> state_r == ADCSQ_CONV && ctrl_r[CTL_GO])
    else $error("go write did not start conversion");
  AST_END_RESULT: assert property (finish |=> !ctrl_r[CTL_GO] && res_r == $past(decided))
    else $error("result not loaded as go cleared");
  AST_DONE_WINS: assert property (finish && ctrl_wr |=> ctrl_r[CTL_DONE])
    else $error("completion flag lost to a write");
  AST_IRQ: assert property (ctrl_r[CTL_DONE] && intc_r[INT_IE] && intc_r[INT_GIE] |=> irq)
    else $error("interrupt request missing");
  AST_WAKE: assert property (finish && intc_r[INT_IE] && core_sleep && !intc_wr
                             |=> ##1 (wake || !core_sleep))
    else $error("no wake after completion in sleep");
  AST_ABORT: assert property (abort && !res_wr |=> state_r == ADCSQ_TRACK
                              && ctrl_r[CTL_DONE] == $past(ctrl_wdata[CTL_DONE])
                              && $stable(res_r))
    else $error("abort changed result or flag");
  AST_RC_CH0: assert property (ctrl_wr && ctrl_wdata == 8'hC0 |=> ctrl_r[CTL_CS_HI:CTL_CS_LO] == CS_RC
                               && ctrl_r[CTL_CH_HI:CTL_CH_LO] == 2'h0)
    else $error("rc clock channel zero not selected");
  AST_ANALOG_ZERO: assert property ((port_read & cfg_mask($past(cfg_r[1:0]))) == 4'h0
                                    || $changed(cfg_r))
    else $error("analog pin read non zero");
  AST_DIR_DRIVE: assert property (##1 shared_analog_pins_oe == ~$past(port_dir_in))
    else $error("pin enable not following direction");
  AST_CHAN_LOCK: assert property (state_r == ADCSQ_CONV && $past(state_r) == ADCSQ_CONV
                                  && hold |-> mux_chan == conv_chan_r)
    else $error("channel moved during conversion");
  AST_LENGTH: assert property (start |-> !finish [*8])
    else $error("conversion ended too early");

  COV_FULL: cover property (start ##[1:400] finish);
  COV_ABORT: cover property (start ##[1:100] abort);
  COV_WAKE: cover property (finish ##2 wake);
endmodule

/* File: tb/adcsq_top_tb.sv */
// adcsq_top_tb: self-checking bench for the converter sequencer block
`timescale 1ns/1ps
module adcsq_top_tb
  import adcsq_pkg::*;
;
  // clock, reset and design inputs
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic ctrl_wr = 1'b0, cfg_wr = 1'b0, intc_wr = 1'b0, res_wr = 1'b0;
  logic [7:0] ctrl_wdata = 8'h00, cfg_wdata = 8'h00, intc_wdata = 8'h00, res_wdata = 8'h00;
  logic core_sleep = 1'b0, rc_osc = 1'b0, comp_hi = 1'b0;
  logic [3:0] shared_analog_pins_in = 4'h0, port_latch = 4'h0, port_dir_in = 4'hF;
  // design outputs
  logic [7:0] ctrl_rdata, cfg_rdata, intc_rdata, res_rdata, dac_code;
  logic irq, wake, hold;
  logic [1:0] mux_chan;
  logic [3:0] shared_analog_pins_out, shared_analog_pins_oe, port_read;
  // bench state
  int err_total = 0, n_checks = 0, cycles = 0;
  integer seed = 32'hA4F7;
  logic [7:0] vin_r = 8'h00, res_last = 8'h00, e;
  logic [7:0] exp_q [$];
  logic go_q = 1'b0;
  logic reference_enable_pin = 1'b0;  // reference generator enable kept by firmware
  logic [3:0] masks [4] = '{CFG_MASK_0, CFG_MASK_1, CFG_MASK_2, CFG_MASK_3};

  adcsq_top adcsq_top_i (.ref_clk(ref_clk), .arst_n(arst_n), .ctrl_wr(ctrl_wr),
    .ctrl_wdata(ctrl_wdata), .ctrl_rdata(ctrl_rdata), .cfg_wr(cfg_wr), .cfg_wdata(cfg_wdata),
    .cfg_rdata(cfg_rdata), .intc_wr(intc_wr), .intc_wdata(intc_wdata), .intc_rdata(intc_rdata),
    .res_wr(res_wr), .res_wdata(res_wdata), .res_rdata(res_rdata), .core_sleep(core_sleep),
    .irq(irq), .wake(wake), .rc_osc(rc_osc), .comp_hi(comp_hi), .dac_code(dac_code),
    .mux_chan(mux_chan), .hold(hold), .shared_analog_pins_in(shared_analog_pins_in),
    .port_latch(port_latch), .port_dir_in(port_dir_in),
    .shared_analog_pins_out(shared_analog_pins_out),
    .shared_analog_pins_oe(shared_analog_pins_oe), .port_read(port_read));

  ////////////////////////////////////////////////////////////////////////
  // clocks and analog model
  always #5 ref_clk = ~ref_clk;
  // free-running rc oscillator, unrelated in phase to the core clock
  always #23 rc_osc = ~rc_osc;
  // ideal comparator: input at or above the trial code
  always @(posedge ref_clk) begin
    #1;
    comp_hi = (vin_r >= dac_code);
  end

  ////////////////////////////////////////////////////////////////////////
  // comparison and closing
  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // hang guard, well above the longest expected run
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 30000) begin
      err_total++;
      summarize();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // result monitor: a falling busy flag takes the oldest note
  always @(negedge ref_clk) begin
    if (go_q && ctrl_rdata[2] === 1'b0) begin
      if (exp_q.size() > 0) begin
        e = exp_q.pop_front();
        check("result", res_rdata, e);
        check("done flag", ctrl_rdata[1], 8'h01);
        check("hold released", hold, 8'h00);
        res_last = e;
      end else begin
        check("done after abort", ctrl_rdata[1], 8'h00);
        check("result kept", res_rdata, res_last);
      end
    end
    go_q <= (ctrl_rdata[2] === 1'b1);
  end

  ////////////////////////////////////////////////////////////////////////
  // register write drivers: one-cycle strobe, changed just after the edge
  task automatic wr_ctrl(input logic [7:0] v);
    @(posedge ref_clk);
    #1 ctrl_wdata = v;
    ctrl_wr = 1'b1;
    @(posedge ref_clk);
    #1 ctrl_wr = 1'b0;
  endtask

  task automatic wr_intc(input logic [7:0] v);
    @(posedge ref_clk);
    #1 intc_wdata = v;
    intc_wr = 1'b1;
    @(posedge ref_clk);
    #1 intc_wr = 1'b0;
  endtask

  // one conversion; nch differing from ch is written mid conversion, the channel holds ch until the end
  task automatic convert(input logic [1:0] cs, input logic [1:0] ch, input logic [1:0] nch);
    int cnt;
    int div;
    cnt = 0;
    div = 2 << (2 * cs);
    vin_r = 8'($random(seed));
    wr_ctrl({cs, 1'b0, ch, 3'b001});
    check("done cleared", ctrl_rdata[1], 8'h00);
    reference_enable_pin = 1'b1;
    repeat (4) @(posedge ref_clk);
    exp_q.push_back(vin_r);
    wr_ctrl({cs, 1'b0, ch, 3'b101});
    check("busy", ctrl_rdata[2], 8'h01);
    check("hold", hold, 8'h01);
    check("first trial", dac_code, 8'h80);
    check("channel", mux_chan, ch);
    if (nch != ch) begin
      wr_ctrl({cs, 1'b0, nch, 3'b101});
      check("channel held", mux_chan, ch);
    end
    while (ctrl_rdata[2] === 1'b1 && cnt < 3000) begin
      @(posedge ref_clk);
      #1 cnt++;
    end
    reference_enable_pin = 1'b0;
    if (cs != CS_RC && nch == ch)
      check("length", 8'(cnt >= 8 * div - 2 && cnt <= 8 * div + 2), 8'h01);
    @(posedge ref_clk);
    #1 check("new channel", mux_chan, nch);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (6) @(posedge ref_clk);
    #1 arst_n = 1'b1;
    check("ctrl reset", ctrl_rdata, CTL_RESET);
    check("cfg reset", cfg_rdata, CFG_RESET);
    check("intc reset", intc_rdata, INT_RESET);
    check("res reset", res_rdata, RES_RESET);
    // go together with power while off is refused
    wr_ctrl(8'h05);
    check("go refused", ctrl_rdata[2], 8'h00);
    wr_ctrl(8'hC0);
    check("rc ch0", ctrl_rdata, 8'hC0);
    check("mux ch0", mux_chan, 8'h00);
    wr_ctrl(8'hD1);
    check("rc ch2 on", ctrl_rdata, 8'hD1);
    @(posedge ref_clk);
    #1 check("mux ch2", mux_chan, 8'h02);
    repeat (500) @(posedge ref_clk);
    // every clock select, channel equal to the code
    for (int k = 0; k < 4; k++) convert(2'(k), 2'(k), 2'(k));
    convert(CS_DIV8, 2'h1, 2'h3);
    // abort in mid conversion
    vin_r = 8'($random(seed));
    wr_ctrl(8'h01);
    repeat (4) @(posedge ref_clk);
    wr_ctrl(8'h05);
    repeat (5) @(posedge ref_clk);
    wr_ctrl(8'h01);
    @(posedge ref_clk);
    #1 check("abort hold", hold, 8'h00);
    // write landing on the finishing edge: completion wins
    vin_r = 8'($random(seed));
    repeat (4) @(posedge ref_clk);
    exp_q.push_back(vin_r);
    wr_ctrl(8'h05);
    repeat (14) @(posedge ref_clk);
    wr_ctrl(8'h05);
    check("done wins", ctrl_rdata[1], 8'h01);
    check("go cleared", ctrl_rdata[2], 8'h00);
    // result as an ordinary register between conversions
    @(posedge ref_clk);
    #1 res_wdata = 8'($random(seed));
    res_wr = 1'b1;
    @(posedge ref_clk);
    #1 res_wr = 1'b0;
    res_last = res_wdata;
    check("result write", res_rdata, res_wdata);
    // sleep wake with converter enable only
    wr_intc(8'h40);
    core_sleep = 1'b1;
    convert(CS_RC, 2'h0, 2'h0);
    check("wake", wake, 8'h01);
    check("no irq", irq, 8'h00);
    core_sleep = 1'b0;
    wr_intc(8'hC0);
    convert(CS_DIV2, 2'h2, 2'h2);
    check("irq", irq, 8'h01);
    check("no wake", wake, 8'h00);
    // shared pins for every configuration code
    for (int k = 0; k < 4; k++) begin
      @(posedge ref_clk);
      #1 cfg_wdata = 8'(k);
      cfg_wr = 1'b1;
      {shared_analog_pins_in, port_latch, port_dir_in} = 12'($random(seed));
      @(posedge ref_clk);
      #1 cfg_wr = 1'b0;
      repeat (4) @(posedge ref_clk);
      #1 check("cfg", cfg_rdata, 8'(k));
      check("pin read", port_read, shared_analog_pins_in & ~masks[k]);
      check("pin oe", shared_analog_pins_oe, {4'h0, ~port_dir_in});
      check("pin out", shared_analog_pins_out, port_latch);
    end
    summarize();
  end
endmodule
